// File: hdl/bcdalu_consts.svh
// register offsets, field positions and reset values of the bcd alu
`ifndef BCDALU_CONSTS_SVH
`define BCDALU_CONSTS_SVH

// ==========================================
// register byte offsets
`define BCDALU_ADDR_CMD 8'h00
`define BCDALU_ADDR_ACC 8'h04
`define BCDALU_ADDR_OPND_LO 8'h08
`define BCDALU_ADDR_OPND_HI 8'h0c
`define BCDALU_ADDR_IMM 8'h10
`define BCDALU_ADDR_FLAGS 8'h14
`define BCDALU_ADDR_IRQ_STATUS 8'h18
`define BCDALU_ADDR_IRQ_MASK 8'h1c

// ==========================================
// field positions
`define BCDALU_CMD_OP_LSB 0
`define BCDALU_CMD_IMM_BIT 2
`define BCDALU_CMD_BUSY_BIT 8
`define BCDALU_EV_DONE 0
`define BCDALU_EV_INVALID 1

// ==========================================
// reset values
`define BCDALU_ACC_RESET 32'h0000_0000
`define BCDALU_OPND_RESET 16'h0000
`define BCDALU_IMM_RESET 32'h0000_0000
`define BCDALU_FLAGS_RESET 7'h00
`define BCDALU_MASK_RESET 2'h0
`define BCDALU_STATUS_RESET 2'h0

`endif

// File: hdl/bcdalu_pkg.sv
// types shared by the bcd alu files
`default_nettype none

package bcdalu_pkg;

	typedef enum logic [1:0] {
		word_sum_op = 2'h0,
		double_sum_op = 2'h1,
		word_difference_op = 2'h2,
		double_difference_op = 2'h3
	} bcdalu_op_t;

	typedef enum logic [1:0] {
		st_idle = 2'h1,
		st_exec = 2'h2
	} bcdalu_state_t;

	typedef struct packed {
		logic invalid_digit_flag;
		logic negative_result_flag;
		logic double_subtract_carry_flag;
		logic word_subtract_carry_flag;
		logic double_sum_carry_flag;
		logic word_sum_carry_flag;
		logic zero_result_flag;
	} bcdalu_flags_t;

	typedef struct packed {
		logic [31:0] a;
		logic [31:0] b;
		logic subtract;
	} bcdalu_operands_t;

	typedef struct packed {
		logic [31:0] result;
		logic carry16;
		logic carry32;
		logic invalid;
	} bcdalu_sum_t;

endpackage : bcdalu_pkg
`default_nettype wire

// File: hdl/bcdalu_adder.sv
// eight digit decimal adder and ten's complement subtractor
`timescale 1ns/100ps
`default_nettype none

module bcdalu_adder (
	// operands
	input wire bcdalu_pkg::bcdalu_operands_t operands,
	// result with digit carries
	output var bcdalu_pkg::bcdalu_sum_t sum
);

	function automatic logic digit_bad(input logic [3:0] d);
		return d > 4'h9;
	endfunction : digit_bad

	function automatic logic [4:0] digit_add(input logic [3:0] x, input logic [3:0] y, input logic c);
		logic [4:0] s;
		logic [4:0] t;
		s = {1'b0, x} + {1'b0, y} + {4'h0, c};
		t = s + 5'h06;
		if (s > 5'h09)
		begin
			return {1'b1, t[3:0]};
		end
		return s;
	endfunction : digit_add

	logic [8:0] carry;
	logic [3:0] bdig;
	logic bad;

	// ==========================================
	// digit chain
	always_comb
	begin
		carry = 9'h000;
		carry[0] = operands.subtract;
		bad = 1'b0;
		bdig = 4'h0;
		sum = '0;
		for (int i = 0; i < 8; i++)
		begin
			bdig = operands.b[4*i +: 4];
			if (operands.subtract)
			begin
				bdig = 4'h9 - bdig;
			end
			{carry[i+1], sum.result[4*i +: 4]} = digit_add(operands.a[4*i +: 4], bdig, carry[i]);
			bad = bad | digit_bad(operands.a[4*i +: 4]) | digit_bad(operands.b[4*i +: 4]);
		end
		sum.carry16 = carry[4];
		sum.carry32 = carry[8];
		sum.invalid = bad;
	end

endmodule : bcdalu_adder
`default_nettype wire

// File: hdl/bcdalu_irq.sv
// sticky event status with read clear and masked level interrupt
`timescale 1ns/100ps
`default_nettype none
`include "bcdalu_consts.svh"

module bcdalu_irq (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// events and software access
	input wire logic [1:0] event_set,
	input wire logic status_read,
	input wire logic [1:0] mask,
	// state out
	output logic [1:0] status,
	output logic irq
);

	logic [1:0] next_status;
	logic next_irq;

	// ==========================================
	// status bits
	always_comb
	begin
		// an event in the clearing cycle survives
		next_status = (status & {2{~status_read}}) | event_set;
		next_irq = |(next_status & mask);
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			status <= `BCDALU_STATUS_RESET;
			irq <= 1'b0;
		end
		else
		begin
			status <= next_status;
			irq <= next_irq;
		end
	end

	// ==========================================
	// checks
	a_irq_set_wins: assert property (@(posedge clock) disable iff (reset)
		status_read && event_set[`BCDALU_EV_DONE] |=> status[`BCDALU_EV_DONE] && !$stable(status) || status[0])
		else $error("event lost while status cleared");
	a_irq_read_clear: assert property (@(posedge clock) disable iff (reset)
		status_read && event_set == 2'h0 |=> status == 2'h0 && !irq)
		else $error("status read did not clear");

endmodule : bcdalu_irq
`default_nettype wire

// File: hdl/bcdalu_top.sv
// bcd add and subtract unit on a 32-bit accumulator behind a wishbone slave
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "bcdalu_consts.svh"

module bcdalu_top (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// status pins
	output var bcdalu_pkg::bcdalu_flags_t flags,
	output logic busy,
	output logic irq
);

	function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] sel);
		logic [31:0] merged;
		merged = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				merged[8*i +: 8] = data[8*i +: 8];
			end
		end
		return merged;
	endfunction : apply_sel

	function automatic logic digits_ok(input logic [31:0] v);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			ok = ok & (v[4*i +: 4] <= 4'h9);
		end
		return ok;
	endfunction : digits_ok

	bcdalu_pkg::bcdalu_state_t state;
	bcdalu_pkg::bcdalu_state_t next_state;
	bcdalu_pkg::bcdalu_op_t cmd_op;
	bcdalu_pkg::bcdalu_op_t next_cmd_op;
	bcdalu_pkg::bcdalu_flags_t next_flags;
	bcdalu_pkg::bcdalu_operands_t operands;
	bcdalu_pkg::bcdalu_sum_t sum;
	logic [31:0] acc;
	logic [31:0] next_acc;
	logic [31:0] imm;
	logic [31:0] next_imm;
	logic [31:0] next_dat;
	logic [31:0] rd_word;
	logic [31:0] wr_word;
	logic [31:0] result;
	logic [15:0] opnd_lo;
	logic [15:0] next_opnd_lo;
	logic [15:0] opnd_hi;
	logic [15:0] next_opnd_hi;
	logic [15:0] acc_low;
	logic [7:0] reg_addr;
	logic [1:0] mask;
	logic [1:0] next_mask;
	logic [1:0] irq_status;
	logic [1:0] events;
	logic cmd_imm;
	logic next_cmd_imm;
	logic next_ack;
	logic next_busy;
	logic take;
	logic status_read;
	logic is_word;
	logic is_diff;

	// ==========================================
	// bus decode and operand selection
	always_comb
	begin
		take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		reg_addr = {wb_adr_i[7:2], 2'b00};
		rd_word = 32'h0000_0000;
		case (reg_addr)
			`BCDALU_ADDR_CMD:
			begin
				rd_word[`BCDALU_CMD_OP_LSB +: 2] = cmd_op;
				rd_word[`BCDALU_CMD_IMM_BIT] = cmd_imm;
				rd_word[`BCDALU_CMD_BUSY_BIT] = busy;
			end
			`BCDALU_ADDR_ACC: rd_word = acc;
			`BCDALU_ADDR_OPND_LO: rd_word = {16'h0000, opnd_lo};
			`BCDALU_ADDR_OPND_HI: rd_word = {16'h0000, opnd_hi};
			`BCDALU_ADDR_IMM: rd_word = imm;
			`BCDALU_ADDR_FLAGS: rd_word = {25'h0000000, flags};
			`BCDALU_ADDR_IRQ_STATUS: rd_word = {30'h00000000, irq_status};
			`BCDALU_ADDR_IRQ_MASK: rd_word = {30'h00000000, mask};
			default: rd_word = 32'h0000_0000;
		endcase
		wr_word = apply_sel(rd_word, wb_dat_i, wb_sel_i);
		// cleared when the data is latched, so a later event is never read away
		status_read = take & ~wb_we_i & (reg_addr == `BCDALU_ADDR_IRQ_STATUS);
		is_word = (cmd_op == bcdalu_pkg::word_sum_op) || (cmd_op == bcdalu_pkg::word_difference_op);
		is_diff = (cmd_op == bcdalu_pkg::word_difference_op) || (cmd_op == bcdalu_pkg::double_difference_op);
		operands.subtract = is_diff;
		// word forms see only the low sixteen bits
		operands.a = is_word ? {16'h0000, acc[15:0]} : acc;
		// word forms ignore the constant select
		// double operand is the word pair or constant
		operands.b = is_word ? {16'h0000, opnd_lo} : (cmd_imm ? imm : {opnd_hi, opnd_lo});
		result = is_word ? {16'h0000, sum.result[15:0]} : sum.result;
		acc_low = acc[15:0];
	end

	bcdalu_adder u_adder (
		.operands(operands),
		.sum(sum)
	);

	// ==========================================
	// registers and sequencing
	always_comb
	begin
		next_state = state;
		next_acc = acc;
		next_imm = imm;
		next_opnd_lo = opnd_lo;
		next_opnd_hi = opnd_hi;
		next_cmd_op = cmd_op;
		next_cmd_imm = cmd_imm;
		next_flags = flags;
		next_mask = mask;
		events = 2'h0;
		next_ack = take;
		next_dat = (take && !wb_we_i) ? rd_word : wb_dat_o;
		// bus spacing keeps writes out of the busy cycle; the guard is a backstop
		if (take && wb_we_i && state == bcdalu_pkg::st_idle)
		begin
			case (reg_addr)
				`BCDALU_ADDR_ACC: next_acc = wr_word;
				`BCDALU_ADDR_OPND_LO: next_opnd_lo = wr_word[15:0];
				`BCDALU_ADDR_OPND_HI: next_opnd_hi = wr_word[15:0];
				`BCDALU_ADDR_IMM: next_imm = wr_word;
				`BCDALU_ADDR_IRQ_MASK: next_mask = wr_word[1:0];
				`BCDALU_ADDR_CMD:
				begin
					next_cmd_op = bcdalu_pkg::bcdalu_op_t'(wr_word[`BCDALU_CMD_OP_LSB +: 2]);
					next_cmd_imm = wr_word[`BCDALU_CMD_IMM_BIT];
					next_state = bcdalu_pkg::st_exec;
				end
				default: next_acc = acc;
			endcase
		end
		case (state)
			bcdalu_pkg::st_idle: next_state = next_state;
			bcdalu_pkg::st_exec:
			begin
				// result replaces accumulator, word forms clear the top half
				next_acc = result;
				// zero flag from the new accumulator
				next_flags.zero_result_flag = (result == 32'h0000_0000);
				// negative from the top result bit
				// top accumulator bit is the sign
				next_flags.negative_result_flag = result[31];
				// any bad operand nibble flags it
				next_flags.invalid_digit_flag = sum.invalid;
				// only the carry of this operation moves
				case (cmd_op)
					bcdalu_pkg::word_sum_op: next_flags.word_sum_carry_flag = sum.carry16;
					bcdalu_pkg::double_sum_op: next_flags.double_sum_carry_flag = sum.carry32;
					bcdalu_pkg::word_difference_op: next_flags.word_subtract_carry_flag = ~sum.carry16;
					bcdalu_pkg::double_difference_op: next_flags.double_subtract_carry_flag = ~sum.carry32;
					default: next_flags = flags;
				endcase
				events[`BCDALU_EV_DONE] = 1'b1;
				events[`BCDALU_EV_INVALID] = sum.invalid;
				next_state = bcdalu_pkg::st_idle;
			end
			default: next_state = bcdalu_pkg::st_idle;
		endcase
		next_busy = (next_state == bcdalu_pkg::st_exec);
	end

	// flags change only on the exec edge
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state <= bcdalu_pkg::st_idle;
			acc <= `BCDALU_ACC_RESET;
			imm <= `BCDALU_IMM_RESET;
			opnd_lo <= `BCDALU_OPND_RESET;
			opnd_hi <= `BCDALU_OPND_RESET;
			cmd_op <= bcdalu_pkg::word_sum_op;
			cmd_imm <= 1'b0;
			flags <= `BCDALU_FLAGS_RESET;
			mask <= `BCDALU_MASK_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			busy <= 1'b0;
		end
		else
		begin
			state <= next_state;
			acc <= next_acc;
			imm <= next_imm;
			opnd_lo <= next_opnd_lo;
			opnd_hi <= next_opnd_hi;
			cmd_op <= next_cmd_op;
			cmd_imm <= next_cmd_imm;
			flags <= next_flags;
			mask <= next_mask;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			busy <= next_busy;
		end
	end

	bcdalu_irq u_irq (
		.clock(clock),
		.reset(reset),
		.event_set(events),
		.status_read(status_read),
		.mask(mask),
		.status(irq_status),
		.irq(irq)
	);

	// ==========================================
	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	sequence s_cmd_write;
		take && wb_we_i && reg_addr == `BCDALU_ADDR_CMD && state == bcdalu_pkg::st_idle;
	endsequence

	sequence s_exec(bcdalu_pkg::bcdalu_op_t op);
		state == bcdalu_pkg::st_exec && cmd_op == op;
	endsequence

	a_bus_ack_once: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");
	a_cmd_runs_once: assert property (s_cmd_write |=> busy && state == bcdalu_pkg::st_exec ##1 !busy)
		else $error("command did not run for one cycle");
	a_word_sum_digits: assert property (
		s_exec(bcdalu_pkg::word_sum_op) ##0 !sum.invalid |=> acc[31:16] == 16'h0000 && digits_ok(acc))
		else $error("word sum not a decimal word");
	a_double_sum_zero: assert property (
		s_exec(bcdalu_pkg::double_sum_op) ##0 (cmd_imm && imm == 32'h0 && !sum.invalid) |=> acc == $past(acc))
		else $error("adding zero constant changed accumulator");
	a_word_diff_zero: assert property (
		s_exec(bcdalu_pkg::word_difference_op) ##0 (opnd_lo == 16'h0 && !sum.invalid)
		|=> acc == {16'h0000, $past(acc_low)} && !flags.word_subtract_carry_flag)
		else $error("subtracting zero word changed low half");
	a_double_diff_self: assert property (
		s_exec(bcdalu_pkg::double_difference_op) ##0 (!cmd_imm && {opnd_hi, opnd_lo} == acc && !sum.invalid)
		|=> acc == 32'h0 && flags.zero_result_flag)
		else $error("self subtraction not zero");
	a_zero_flag_tracks: assert property (
		state == bcdalu_pkg::st_exec |=> flags.zero_result_flag == (acc == 32'h0))
		else $error("zero flag disagrees with accumulator");
	a_word_carry_out: assert property (
		s_exec(bcdalu_pkg::word_sum_op) ##0 (acc[15:0] == 16'h9999 && opnd_lo == 16'h0001)
		|=> flags.word_sum_carry_flag && acc == 32'h0)
		else $error("word carry missing");
	a_double_carry_out: assert property (
		s_exec(bcdalu_pkg::double_sum_op) ##0 (acc == 32'h9999_9999 && operands.b == 32'h0000_0001)
		|=> flags.double_sum_carry_flag && flags.zero_result_flag)
		else $error("double carry missing");
	a_word_borrow_flag: assert property (
		s_exec(bcdalu_pkg::word_difference_op) ##0 !sum.invalid
		|=> flags.word_subtract_carry_flag == ($past(acc_low) < $past(opnd_lo)))
		else $error("word subtract carry wrong");
	a_double_borrow_flag: assert property (
		s_exec(bcdalu_pkg::double_difference_op) ##0 (!sum.invalid && acc < operands.b)
		|=> flags.double_subtract_carry_flag)
		else $error("double subtract carry missing");
	a_negative_top_bit: assert property (
		state == bcdalu_pkg::st_exec |=> flags.negative_result_flag == acc[31])
		else $error("negative flag not the top bit");
	a_invalid_digit: assert property (
		s_exec(bcdalu_pkg::word_sum_op) ##0 (!digits_ok({16'h0000, acc_low}) || !digits_ok({16'h0000, opnd_lo}))
		|=> flags.invalid_digit_flag)
		else $error("bad digit not flagged");
	a_flags_hold_idle: assert property (
		state == bcdalu_pkg::st_idle |=> $stable(flags))
		else $error("flags moved without an operation");
	a_word_sum_keeps: assert property (
		s_exec(bcdalu_pkg::word_sum_op)
		|=> $stable(flags.double_sum_carry_flag) && $stable(flags.word_subtract_carry_flag)
		&& $stable(flags.double_subtract_carry_flag))
		else $error("word sum touched foreign carry");

endmodule : bcdalu_top
`default_nettype wire

// File: sim/bcdalu_seq_model.sv
// sequencer model: operand memory and command framing
`timescale 1ns/100ps
`default_nettype none

module bcdalu_seq_model (
	// operand fetch
	input wire logic [1:0] word_addr,
	input wire logic [1:0] op,
	input wire logic want_const,
	// values for the register bus
	output logic [15:0] word_first,
	output logic [15:0] word_second,
	output logic [31:0] cmd_word
);
	logic [15:0] mem [0:4];

	initial
	begin
		mem[0] = 16'h8766;
		mem[1] = 16'h0055;
		mem[2] = 16'h0001;
		mem[3] = 16'h0000;
		mem[4] = 16'h0000;
	end

	// first word of a pair is the low half
	assign word_first = mem[word_addr];
	assign word_second = mem[{1'b0, word_addr} + 3'h1];
	assign cmd_word = {29'h0, want_const & op[0], op};
endmodule : bcdalu_seq_model
`default_nettype wire

// File: sim/tb_bcd_add_sub_accumulator_alu.sv
// self-checking bench of the bcd alu
`timescale 1ns/100ps
`default_nettype none
`include "bcdalu_consts.svh"

module tb_bcd_add_sub_accumulator_alu;
	typedef struct packed {
		logic [31:0] acc;
		logic [1:0] addr;
		logic [31:0] imm;
		logic [1:0] op;
		logic konst;
		logic [31:0] exp_acc;
		logic [6:0] exp_flags;
	} bcdalu_row_t;

	logic clock;
	logic reset;
	logic wb_cyc_i;
	logic wb_stb_i;
	logic wb_we_i;
	logic [3:0] wb_sel_i;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	bcdalu_pkg::bcdalu_flags_t flags;
	logic busy;
	logic irq;
	logic [1:0] word_addr;
	logic [1:0] op;
	logic want_const;
	logic [15:0] word_first;
	logic [15:0] word_second;
	logic [31:0] cmd_word;
	logic [31:0] d;
	bcdalu_row_t rows [0:11];
	int bad_count;
	int comparisons;

	bcdalu_top bcdalu_top_inst (
		.clock(clock),
		.reset(reset),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_sel_i(wb_sel_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.flags(flags),
		.busy(busy),
		.irq(irq)
	);

	bcdalu_seq_model bcdalu_seq_model_inst (
		.word_addr(word_addr),
		.op(op),
		.want_const(want_const),
		.word_first(word_first),
		.word_second(word_second),
		.cmd_word(cmd_word)
	);

	initial
	begin
		clock = 1'b0;
	end

	always #50 clock = ~clock;

	// ==========================================
	// checking and closing
	task conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	task check(input string name, input logic [31:0] seen, input logic [31:0] expected);
		comparisons++;
		if (seen !== expected)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, expected, seen);
		end
	endtask : check

	// ==========================================
	// wishbone classic master
	task wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		wb_sel_i <= 4'hf;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 16);
		rd = wb_dat_o;
		if (wb_ack_o !== 1'b1)
		begin
			bad_count++;
			$display("mismatch wb_ack_o expected 1 seen %b", wb_ack_o);
			conclude();
		end
		else
		begin
			check("ack latency", n, 32'h2);
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_we_i <= 1'b0;
			@(posedge clock);
		end
	endtask : wb_cycle

	task wb_write(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] unused;
		wb_cycle(1'b1, a, wd, unused);
	endtask : wb_write

	task wb_read(input logic [7:0] a, output logic [31:0] rd);
		wb_cycle(1'b0, a, 32'h0, rd);
	endtask : wb_read

	task run_op(input logic [31:0] acc);
		wb_write(`BCDALU_ADDR_ACC, acc);
		wb_write(`BCDALU_ADDR_OPND_LO, {16'h0, word_first});
		wb_write(`BCDALU_ADDR_OPND_HI, {16'h0, word_second});
		wb_write(`BCDALU_ADDR_CMD, cmd_word);
	endtask : run_op

	// ==========================================
	// main sequence
	initial
	begin
		reset = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_sel_i = 4'h0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		{word_addr, op, want_const} = 5'h00;
		bad_count = 0;
		comparisons = 0;
		rows[0] = '{32'h5555_1234, 2'h0, 32'h0, 2'h0, 1'b1, 32'h0000_0000, 7'h03};
		rows[1] = '{32'h0000_0045, 2'h1, 32'h0, 2'h0, 1'b0, 32'h0000_0100, 7'h00};
		rows[2] = '{32'h9999_9999, 2'h2, 32'h0, 2'h1, 1'b0, 32'h0000_0000, 7'h05};
		rows[3] = '{32'h1234_5678, 2'h1, 32'h8765_4321, 2'h1, 1'b1, 32'h9999_9999, 7'h20};
		rows[4] = '{32'h0000_0100, 2'h2, 32'h0, 2'h2, 1'b1, 32'h0000_0099, 7'h00};
		rows[5] = '{32'h0000_0000, 2'h2, 32'h0, 2'h2, 1'b0, 32'h0000_9999, 7'h08};
		rows[6] = '{32'h0000_0000, 2'h2, 32'h0, 2'h3, 1'b0, 32'h9999_9999, 7'h38};
		rows[7] = '{32'h5000_0000, 2'h0, 32'h5000_0000, 2'h3, 1'b1, 32'h0000_0000, 7'h09};
		// zero constant, full word carry, zero subtrahend, self subtraction
		rows[8] = '{32'h1234_5678, 2'h0, 32'h0, 2'h1, 1'b1, 32'h1234_5678, 7'h08};
		rows[9] = '{32'h4444_9999, 2'h2, 32'h0, 2'h0, 1'b0, 32'h0000_0000, 7'h0b};
		rows[10] = '{32'h0000_4321, 2'h3, 32'h0, 2'h2, 1'b0, 32'h0000_4321, 7'h02};
		rows[11] = '{32'h0001_0055, 2'h1, 32'h0, 2'h3, 1'b0, 32'h0000_0000, 7'h03};
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		check("flags", {25'h0, flags}, 32'h0);
		check("busy", {31'h0, busy}, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		wb_read(`BCDALU_ADDR_ACC, d);
		check("acc", d, 32'h0);
		wb_read(`BCDALU_ADDR_IRQ_MASK, d);
		check("irq mask", d, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 12; i++)
		begin
			word_addr = rows[i].addr;
			op = rows[i].op;
			want_const = rows[i].konst;
			wb_write(`BCDALU_ADDR_IMM, rows[i].imm);
			run_op(rows[i].acc);
			wb_read(`BCDALU_ADDR_ACC, d);
			check("acc", d, rows[i].exp_acc);
			check("flags", {25'h0, flags}, {25'h0, rows[i].exp_flags});
			wb_read(`BCDALU_ADDR_FLAGS, d);
			check("flags reg", d, {25'h0, rows[i].exp_flags});
			$display("test row %0d done", i);
		end
		// masked done event, then unmasked invalid digit
		wb_read(`BCDALU_ADDR_IRQ_STATUS, d);
		check("irq status", d, 32'h1);
		wb_read(`BCDALU_ADDR_IRQ_STATUS, d);
		check("irq status cleared", d, 32'h0);
		wb_write(`BCDALU_ADDR_IRQ_MASK, 32'h2);
		word_addr = 2'h2;
		op = 2'h0;
		want_const = 1'b0;
		run_op(32'h0000_0001);
		repeat (2) @(posedge clock);
		check("irq masked", {31'h0, irq}, 32'h0);
		wb_read(`BCDALU_ADDR_IRQ_STATUS, d);
		check("irq status", d, 32'h1);
		run_op(32'h0000_000a);
		repeat (2) @(posedge clock);
		check("invalid flag", {31'h0, flags.invalid_digit_flag}, 32'h1);
		check("irq", {31'h0, irq}, 32'h1);
		wb_read(`BCDALU_ADDR_IRQ_STATUS, d);
		check("irq status", d, 32'h3);
		repeat (2) @(posedge clock);
		check("irq after clear", {31'h0, irq}, 32'h0);
		$display("test interrupt done");
		// read-only and unmapped places
		wb_write(8'h20, 32'hffff_ffff);
		wb_read(8'h20, d);
		check("unmapped", d, 32'h0);
		wb_write(`BCDALU_ADDR_FLAGS, 32'h0);
		wb_read(`BCDALU_ADDR_FLAGS, d);
		check("flags reg", {31'h0, d[6]}, 32'h1);
		$display("test unmapped done");
		// second reset in mid-run
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		check("flags", {25'h0, flags}, 32'h0);
		wb_read(`BCDALU_ADDR_ACC, d);
		check("acc", d, 32'h0);
		wb_read(`BCDALU_ADDR_IRQ_MASK, d);
		check("irq mask", d, 32'h0);
		$display("test second reset done");
		conclude();
	end
endmodule : tb_bcd_add_sub_accumulator_alu
`default_nettype wire
